/* File: rtl/ctm_defines.vh */
// Constants for the compact timer: APB offsets, fields, encodings, reset values.
// Assumes inclusion by bare name from the timer design files.
`ifndef CTM_DEFINES_VH
`define CTM_DEFINES_VH

// Register byte offsets
`define CTM_OFF_CTRL0        12'h000
`define CTM_OFF_CTRL1        12'h004
`define CTM_OFF_COUNT        12'h008
`define CTM_OFF_CMPA         12'h00c
`define CTM_OFF_PERIOD       12'h010
`define CTM_OFF_FLAGS        12'h014

// Control 0 fields
`define CTM_C0_PAUSE         7
`define CTM_C0_CLK_HI        6
`define CTM_C0_CLK_LO        4
`define CTM_C0_ENABLE        3

// Control 1 fields
`define CTM_C1_MODE_HI       7
`define CTM_C1_MODE_LO       6
`define CTM_C1_ACT_HI        5
`define CTM_C1_ACT_LO        4
`define CTM_C1_INIT          3
`define CTM_C1_INVERT        2
`define CTM_C1_SWAP          1
`define CTM_C1_CLRSEL        0

// Flag register fields
`define CTM_FL_A             0
`define CTM_FL_P             1

// Modes
`define CTM_MODE_COMPARE     2'h0
`define CTM_MODE_PWM         2'h2
`define CTM_MODE_TIMER       2'h3

// Pin actions, compare mode
`define CTM_ACT_NONE         2'h0
`define CTM_ACT_LOW          2'h1
`define CTM_ACT_HIGH         2'h2
`define CTM_ACT_TOGGLE       2'h3

// Pin actions, PWM mode
`define CTM_PWM_INACTIVE     2'h0
`define CTM_PWM_ACTIVE       2'h1
`define CTM_PWM_WAVE         2'h2

// Clock select codes
`define CTM_CK_DIV4          3'h0
`define CTM_CK_SYS           3'h1
`define CTM_CK_DIV16         3'h2
`define CTM_CK_DIV64         3'h3
`define CTM_CK_EXT_RISE      3'h6
`define CTM_CK_EXT_FALL      3'h7

// Reset values and limits
`define CTM_RST_BYTE         8'h00
`define CTM_RST_WORD         16'h0000
`define CTM_COUNT_MAX        16'hffff

`endif

/* File: rtl/ctm_tick_gen.v */
// Counting-clock tick source for the compact timer.
// Assumes ext_clk_in is already synchronous to pclk; sub clock uses the div64 tap.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defines.vh"

module ctm_tick_gen
(
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Selection
  input  wire [2:0] clk_sel,
  input  wire       ext_clk_in,
  // Tick
  output reg        tick_q
);

  reg  [5:0] div_q;
  reg        ext_q;
  reg        tick_d;

  // Free-running prescaler and external level history
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= 6'h00;
      ext_q  <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_q + 6'h01;
      ext_q  <= ext_clk_in;
      tick_q <= tick_d;
    end
  end

  // Tick one cycle per selected clock period; codes 4 and 5 share the slowest tap
  always @*
  begin
    if (clk_sel == `CTM_CK_DIV4)
      tick_d = (div_q[1:0] == 2'h3);
    else if (clk_sel == `CTM_CK_SYS)
      tick_d = 1'b1;
    else if (clk_sel == `CTM_CK_DIV16)
      tick_d = (div_q[3:0] == 4'hf);
    else if (clk_sel == `CTM_CK_EXT_RISE)
      tick_d = ext_clk_in & ~ext_q;
    else if (clk_sel == `CTM_CK_EXT_FALL)
      tick_d = ~ext_clk_in & ext_q;
    else
      tick_d = (div_q == 6'h3f);
  end

endmodule
`default_nettype wire

/* File: rtl/ctm_timer.v */
// Compact 16-bit timer: compare output, timer/counter and edge-aligned PWM modes.
// Assumes an APB master on pclk; the output pin is shared, pin_oe says when it is ours.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defines.vh"

module ctm_timer
#(
  parameter CNT_W = 16
)
(
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Timer pins
  input  wire        ext_clk_in,
  output reg         pin_out,
  output reg         pin_oe
);

  // Software-visible state
  reg  [7:0]       ctrl0_q;
  reg  [7:0]       ctrl1_q;
  reg  [15:0]      cmpa_q;
  reg  [7:0]       period_q;
  reg              flag_a_q;
  reg              flag_p_q;
  // Timer core state
  reg  [CNT_W-1:0] count_q;
  reg  [CNT_W-1:0] count_d;
  reg              en_q;
  reg              pin_q;
  reg              pin_d;
  reg              pwm_act_q;
  reg              pwm_act_d;
  reg              set_a;
  reg              set_p;

  wire             tick;
  wire             acc;
  wire             wr;
  wire [1:0]       mode;
  wire [1:0]       act;
  wire             enable;
  wire             en_rise;
  wire             run;
  wire             match_a;
  wire             match_p;
  wire             ovf;
  wire             in_pwm;
  // Register selects and access decode
  wire             setup;
  wire             sel_ctrl0;
  wire             sel_ctrl1;
  wire             sel_count;
  wire             sel_cmpa;
  wire             sel_period;
  wire             sel_flags;
  wire             clr_a;
  wire             clr_p;
  // PWM phase events
  wire             period_end;
  wire             duty_end;
  // Next values of the registered outputs
  reg              pwm_level;
  reg              pin_out_d;
  reg              pin_oe_d;
  reg  [31:0]      prdata_d;
  reg              pslverr_d;

  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign mode   = ctrl1_q[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
  assign act    = ctrl1_q[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
  assign in_pwm = (mode == `CTM_MODE_PWM);
  assign enable = ctrl0_q[`CTM_C0_ENABLE];
  assign en_rise = enable & ~en_q;
  // count only when enabled, not paused, on a tick
  assign run    = enable & ~ctrl0_q[`CTM_C0_PAUSE] & tick & ~en_rise;
  // Matches are seen on the tick that steps onto the compare value
  // period value meets the upper byte only
  assign match_p = run & (count_q[CNT_W-1:CNT_W-8] + 8'h01 == period_q) & (count_q[7:0] == 8'hff);
  // a zero compare A never matches
  assign match_a = run & (cmpa_q != `CTM_RST_WORD) & (count_q + 16'h0001 == cmpa_q);
  assign ovf     = run & (count_q == `CTM_COUNT_MAX);

  // Register selects; one decode shared by the write and read paths
  assign setup      = psel & ~penable;
  assign sel_ctrl0  = (paddr == `CTM_OFF_CTRL0);
  assign sel_ctrl1  = (paddr == `CTM_OFF_CTRL1);
  assign sel_count  = (paddr == `CTM_OFF_COUNT);
  assign sel_cmpa   = (paddr == `CTM_OFF_CMPA);
  assign sel_period = (paddr == `CTM_OFF_PERIOD);
  assign sel_flags  = (paddr == `CTM_OFF_FLAGS);

  // software clears a flag by writing a one back to it
  assign clr_a = wr & sel_flags & pwdata[`CTM_FL_A];
  assign clr_p = wr & sel_flags & pwdata[`CTM_FL_P];

  // a zero period register lets the counter overflow instead
  // The swap bit only exchanges roles; both comparators keep flagging
  assign period_end = ctrl1_q[`CTM_C1_SWAP] ? match_a : (match_p | (ovf & (period_q == `CTM_RST_BYTE)));
  assign duty_end   = ctrl1_q[`CTM_C1_SWAP] ? (match_p | (ovf & (period_q == `CTM_RST_BYTE))) : match_a;

  ctm_tick_gen u_tick
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_sel    (ctrl0_q[`CTM_C0_CLK_HI:`CTM_C0_CLK_LO]),
    .ext_clk_in (ext_clk_in),
    .tick_q     (tick)
  );

  // Counter next value and flag events
  always @*
  begin
    count_d = count_q;
    set_a   = match_a;
    set_p   = 1'b0;
    if (en_rise)
      count_d = `CTM_RST_WORD;
    else if (run)
    begin
      count_d = count_q + 16'h0001;
      if (in_pwm)
      begin
        set_p = match_p;
        if (ctrl1_q[`CTM_C1_SWAP] ? match_a : match_p)
          count_d = `CTM_RST_WORD;
      end
      else if (ctrl1_q[`CTM_C1_CLRSEL])
      begin
        // clear on A, no P flag
        if (match_a)
          count_d = `CTM_RST_WORD;
      end
      else
      begin
        // clear on P match; overflow wraps when period is zero
        set_p = match_p;
        if (match_p)
          count_d = `CTM_RST_WORD;
      end
    end
  end

  // PWM active phase and pin next state
  always @*
  begin
    pwm_act_d = pwm_act_q;
    pin_d     = pin_q;
    if (en_rise)
    begin
      // load initial level; PWM begins active
      pin_d     = ctrl1_q[`CTM_C1_INIT];
      pwm_act_d = 1'b1;
    end
    else if (in_pwm && run)
    begin
      // a period clear restarts the active phase
      // duty at or above period never ends the active phase
      // duty comes from the other register
      // Period end wins so a duty equal to the period stays fully active
      if (period_end)
        pwm_act_d = 1'b1;
      else if (duty_end)
        pwm_act_d = 1'b0;
    end
    else if (mode == `CTM_MODE_COMPARE && match_a)
    begin
      // only A matches move the pin
      if (act == `CTM_ACT_LOW)
        pin_d = 1'b0;
      else if (act == `CTM_ACT_HIGH)
        pin_d = 1'b1;
      else if (act == `CTM_ACT_TOGGLE)
        pin_d = ~pin_q;
    end
  end

  // Core registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q   <= `CTM_RST_WORD;
      en_q      <= 1'b0;
      pin_q     <= 1'b0;
      pwm_act_q <= 1'b0;
    end
    else
    begin
      count_q   <= count_d;
      en_q      <= enable;
      pin_q     <= pin_d;
      pwm_act_q <= pwm_act_d;
    end
  end

  // Pin next level; PWM level is the active level xor invert, forced values skip the wave
  // Action code 11 in PWM mode is left as wave output; software must not use it
  always @*
  begin
    pwm_level = ~(pwm_act_q ^ ctrl1_q[`CTM_C1_INIT]);
    pin_oe_d  = (mode == `CTM_MODE_COMPARE) | in_pwm;
    pin_out_d = pin_q ^ ctrl1_q[`CTM_C1_INVERT];
    if (in_pwm)
    begin
      if (act == `CTM_PWM_INACTIVE)
        pin_out_d = ~ctrl1_q[`CTM_C1_INIT] ^ ctrl1_q[`CTM_C1_INVERT];
      else if (act == `CTM_PWM_ACTIVE)
        pin_out_d = ctrl1_q[`CTM_C1_INIT] ^ ctrl1_q[`CTM_C1_INVERT];
      else
        pin_out_d = pwm_level ^ ctrl1_q[`CTM_C1_INVERT];
    end
  end

  // Pin registers; one cycle behind the core so the pin never glitches on decode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end
    else
    begin
      pin_out <= pin_out_d;
      pin_oe  <= pin_oe_d;
    end
  end

  // APB writes and sticky flags; a new event beats a clear in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_q  <= `CTM_RST_BYTE;
      ctrl1_q  <= `CTM_RST_BYTE;
      cmpa_q   <= `CTM_RST_WORD;
      period_q <= `CTM_RST_BYTE;
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end
    else
    begin
      // Unused low bits of control 0 always read back as zero
      if (wr && sel_ctrl0)
        ctrl0_q <= {pwdata[7:3], 3'h0};
      else if (wr && sel_ctrl1)
        ctrl1_q <= pwdata[7:0];
      else if (wr && sel_cmpa)
        cmpa_q <= pwdata[15:0];
      else if (wr && sel_period)
        period_q <= pwdata[7:0];
      // flags hold until a one is written back
      if (set_a)
        flag_a_q <= 1'b1;
      else if (clr_a)
        flag_a_q <= 1'b0;
      if (set_p)
        flag_p_q <= 1'b1;
      else if (clr_p)
        flag_p_q <= 1'b0;
    end
  end

  // Read mux; data are picked in setup so they stand through the access cycle
  // The count is a snapshot from setup, up to one tick older than at the access edge
  always @*
  begin
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (setup)
    begin
      if (sel_ctrl0)
        prdata_d = {24'h000000, ctrl0_q};
      else if (sel_ctrl1)
        prdata_d = {24'h000000, ctrl1_q};
      else if (sel_count)
        prdata_d = {16'h0000, count_q};
      else if (sel_cmpa)
        prdata_d = {16'h0000, cmpa_q};
      else if (sel_period)
        prdata_d = {24'h000000, period_q};
      else if (sel_flags)
        prdata_d = {30'h00000000, flag_p_q, flag_a_q};
      else
        pslverr_d = 1'b1;
    end
  end

  // APB answer: one setup, one access cycle, no wait
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
    end
  end

endmodule
`default_nettype wire

/* File: tb/ctm_timer_assertions.sv */
// Port checker for the compact timer.
// Assumes it is bound into every ctm_timer.
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_chk
#(
  parameter CNT_W = 16
)
(
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        ext_clk_in,
  input wire logic        pin_out,
  input wire logic        pin_oe
);
  logic       en_q;
  logic [7:0] c1_q;
  logic [1:0] qt_q;
  wire        wr = psel & penable & pready & pwrite;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Shadow control bits; idle count lets pin updates settle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      en_q <= 1'h0;
      c1_q <= 8'h00;
      qt_q <= 2'h0;
    end
    else
    begin
      if (wr && paddr == 12'h000)
        en_q <= pwdata[3];
      if (wr && paddr == 12'h004)
        c1_q <= pwdata[7:0];
      qt_q <= psel ? 2'h0 : qt_q + {1'h0, qt_q != 2'h3};
    end

  apb_answer_a: assert property (psel && !penable |=> pready && penable)
    else $error("no answer after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_read_a: assert property (pready && !pwrite && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  init_level_a: assert property (
    wr && paddr == 12'h000 && pwdata[3] && !en_q && c1_q[7:6] == 2'h0 |-> ##3 pin_out == (c1_q[3] ^ c1_q[2]))
    else $error("pin not at initial level");
  idle_hold_a: assert property (!en_q && qt_q == 2'h3 |=> $stable(pin_out) && $stable(pin_oe))
    else $error("pin moved while stopped");
  timer_pin_a: assert property (c1_q[7:6] == 2'h3 && qt_q == 2'h3 |-> !pin_oe)
    else $error("pin driven in timer mode");
  pwm_force_a: assert property (
    en_q && c1_q[7:5] == 3'h4 && qt_q == 2'h3 |-> pin_out == ((c1_q[4] ~^ c1_q[3]) ^ c1_q[2]))
    else $error("forced level wrong");

  cover property (wr && paddr == 12'h000 && pwdata[3]);
  cover property (pslverr);
  cover property (en_q && c1_q[7:6] == 2'h2 && pin_out);
endmodule

bind ctm_timer ctm_timer_chk #(.CNT_W(CNT_W)) i_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
  .pin_out(pin_out), .pin_oe(pin_oe)
);
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench for the compact timer over APB.
// Assumes the system clock as count source; external count input idle.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd_v;
  logic [31:0] cnt_v;
  logic        err_v;
  int          num_errors = 0;
  int          total_checks = 0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         pin_out;
  wire         pin_oe;

  ctm_timer i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_in(1'h0),
    .pin_out(pin_out), .pin_oe(pin_oe)
  );

  // 100 ns clock
  always #50 pclk = ~pclk;

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer, held until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'h0, 32'h0);
    chk(rd_v, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // stop first so mode and pin action never change while running
  task automatic go(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    apb(12'h000, 1'h1, 32'h0);
    apb(12'h014, 1'h1, 32'h3);
    apb(12'h00c, 1'h1, {16'h0, a});
    apb(12'h010, 1'h1, {24'h0, p});
    apb(12'h004, 1'h1, {24'h0, c1});
    apb(12'h000, 1'h1, 32'h18);
  endtask

  // Sliding window of one period gives the exact high time
  task automatic pm(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p, input int w, he, fe);
    int hi;
    hi = 0;
    go(c1, a, p);
    cyc(4);
    repeat (w)
    begin
      @(posedge pclk);
      hi += (pin_out === 1'h1);
    end
    chk(32'(hi), 32'(he));
    rdc(12'h014, 32'(fe));
  endtask

  initial
  begin
    cyc(12);
    presetn <= 1'h1;
    for (int i = 0; i < 6; i++)
      rdc(12'(4 * i), 32'h0);
    apb(12'h018, 1'h0, 32'h0);
    chk({31'h0, err_v}, 32'h1);
    // Every compare action; init chosen so each action shows
    for (int a = 0; a < 4; a++)
    begin
      go({2'h0, a[1:0], a == 1, 3'h0}, 16'h40, 8'h1);
      cyc(3);
      chk({31'h0, pin_out}, {31'h0, a == 1});
      cyc(100);
      chk({30'h0, pin_oe, pin_out}, {30'h0, 1'h1, a[1]});
      rdc(12'h014, 32'h1);
      cyc(170);
      rdc(12'h014, 32'h3);
      chk({31'h0, pin_out}, {31'h0, a[1]});
    end
    go(8'h01, 16'h180, 8'h1);
    cyc(500);
    rdc(12'h014, 32'h1);
    apb(12'h008, 1'h0, 32'h0);
    chk({31'h0, rd_v < 32'h180}, 32'h1);
    // Stop holds the count, restart clears it
    apb(12'h000, 1'h1, 32'h0);
    apb(12'h008, 1'h0, 32'h0);
    cnt_v = rd_v;
    cyc(5);
    rdc(12'h008, cnt_v);
    apb(12'h000, 1'h1, 32'h18);
    apb(12'h008, 1'h0, 32'h0);
    chk({31'h0, rd_v < 32'h10}, 32'h1);
    go(8'h00, 16'h0, 8'h0);
    cyc(300);
    apb(12'h014, 1'h0, 32'h0);
    chk(rd_v & 32'h1, 32'h0);
    apb(12'h008, 1'h0, 32'h0);
    chk({31'h0, rd_v > 32'h100}, 32'h1);
    go(8'hf0, 16'h40, 8'h1);
    cyc(100);
    rdc(12'h014, 32'h1);
    chk({31'h0, pin_oe}, 32'h0);
    pm(8'ha8, 16'h40, 8'h1, 256, 64, 3);
    pm(8'hac, 16'h40, 8'h1, 256, 192, 3);
    pm(8'ha9, 16'h40, 8'h1, 256, 64, 3);
    pm(8'ha8, 16'h200, 8'h1, 256, 256, 2);
    pm(8'haa, 16'h200, 8'h1, 512, 256, 3);
    pm(8'h98, 16'h40, 8'h1, 256, 256, 3);
    pm(8'h88, 16'h40, 8'h1, 256, 0, 3);
    stop_test();
  end

  // Hang guard, well above the run length
  initial
  begin
    cyc(20000);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
